// File: core/gzc_top.sv
`timescale 1ns/1ps
// Functional notes
// R01 - power-up measures, streams two results per second
// R02 - fixed rate; early requests get latest result
// R03 - sleep mode: no measuring, immediate answers
// R04 - sleep mode rejects reporting and zero commands
// R05 - sleep mode not kept over power cycle
// R06 - streaming default; commands deferred during measurement
// R07 - polling: measure silently, send when asked
// R08 - stream/poll choice kept in non-volatile store
// R09 - host holds zero pins low three seconds
// R10 - new zero replaces old zero point
// R11 - raw unfiltered result also readable
// R12 - filter setting selectable; larger smooths more
// R13 - host should use filter 32 before zeroing
// R14 - nitrogen zero assumes zero carbon dioxide
// R15 - fresh-air zero uses 400 unless rewritten
// R16 - short zero pin pulse is ignored
// R17 - zero pins ignored in sleep mode
module gzc_top #(
  parameter int unsigned MEAS_PERIOD = gzc_pkg::MEAS_CYC,
  parameter int unsigned ZERO_HOLD = gzc_pkg::ZERO_LOW_CYC,
  parameter int unsigned BUSY_LEN = gzc_pkg::DEFER_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] raw_sample,
  input wire logic [1:0] nv_mode_in,
  output logic [1:0] nv_mode_out,
  output logic nv_mode_wr,
  output logic meas_trig,
  output logic tx_valid,
  output logic [15:0] tx_data,
  input wire logic n2_zero_n,
  input wire logic fresh_zero_n
);
  import gzc_pkg::*;

  localparam int unsigned PW = $clog2(MEAS_PERIOD + 1);
  localparam int unsigned ZW = $clog2(ZERO_HOLD + 1);
  localparam int unsigned BW = $clog2(BUSY_LEN + 1);

  function automatic logic [15:0] sat_sub(input logic [15:0] a, input logic [15:0] b);
    sat_sub = (a > b) ? a - b : 16'h0000;
  endfunction : sat_sub

  function automatic logic [3:0] filt_shift(input logic [7:0] s);
    filt_shift = 4'h0;
    for (int i = 1; i < 8; i++) begin
      if (s[i]) begin
        filt_shift = 4'(i);
      end
    end
  endfunction : filt_shift

  // ==========================================
  // state
  gzc_mode_t mode_ff;
  logic boot_ff;
  logic [7:0] filt_set_ff;
  logic [15:0] fresh_ref_ff;
  logic [15:0] zero_ff;
  logic [15:0] last_raw_ff;
  logic [15:0] conc_ff;
  logic [15:0] filt_ff;
  logic valid_ff;
  logic [PW-1:0] per_cnt_ff;
  logic [BW-1:0] busy_cnt_ff;
  logic [2:0] n2_sync_ff;
  logic [2:0] fa_sync_ff;
  logic n2_lvl_ff;
  logic fa_lvl_ff;
  logic [ZW-1:0] n2_cnt_ff;
  logic [ZW-1:0] fa_cnt_ff;
  logic n2_done_ff;
  logic fa_done_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [1:0] nv_out_ff;
  logic nv_wr_ff;
  logic trig_ff;
  logic tx_valid_ff;
  logic [15:0] tx_data_ff;

  // ==========================================
  // bus decode
  wire [7:0] ofs = paddr[7:0];
  wire in_range = (paddr[31:8] == 24'h000000);
  wire sleeping = (mode_ff == GZC_SLEEP);
  wire busy = (busy_cnt_ff != '0);
  // answer waits out the measurement window in streaming mode [R06]
  wire defer = busy && (mode_ff == GZC_STREAM);
  wire pending = psel && penable && !pready_ff && !defer;
  wire commit = psel && penable && pready_ff && !pslverr_ff;
  wire hit_ctrl = in_range && ofs == OFS_CTRL;
  wire hit_stat = in_range && ofs == OFS_STATUS;
  wire hit_filt = in_range && ofs == OFS_FILT;
  wire hit_raw = in_range && ofs == OFS_RAW;
  wire hit_zero = in_range && ofs == OFS_ZERO;
  wire hit_fresh = in_range && ofs == OFS_FRESH;
  wire hit_cmd = in_range && ofs == OFS_CMD;
  wire [1:0] wr_mode = pwdata[CTRL_MODE_LSB +: 2];
  // reporting and zero-changing accesses refused while asleep [R04]
  wire bad_sleep = sleeping && ((!pwrite && (hit_filt || hit_raw)) || (pwrite && (hit_fresh || hit_cmd)));
  wire bad_map = !(hit_ctrl || hit_stat || hit_filt || hit_raw || hit_zero || hit_fresh || hit_cmd);
  wire bad_dir = pwrite ? (hit_stat || hit_filt || hit_raw || hit_zero) : hit_cmd;
  wire bad_mode = pwrite && hit_ctrl && wr_mode == 2'b11;
  wire acc_err = bad_sleep || bad_map || bad_dir || bad_mode;
  wire [31:0] rd_mux = hit_ctrl ? {16'h0000, filt_set_ff, 6'h00, mode_ff} :
                       hit_stat ? {24'h000000, valid_ff, fa_lvl_ff, n2_lvl_ff, busy, nv_out_ff, mode_ff} :
                       hit_filt ? {16'h0000, filt_ff} : // [R02]
                       hit_raw ? {16'h0000, conc_ff} : // [R11]
                       hit_zero ? {16'h0000, zero_ff} :
                       hit_fresh ? {16'h0000, fresh_ref_ff} : 32'h00000000;
  wire wr_ctrl = commit && pwrite && hit_ctrl;
  wire wr_cmd = commit && pwrite && hit_cmd;
  wire poll_req = wr_cmd && pwdata[CMD_POLL_BIT];
  wire wr_fresh = commit && pwrite && hit_fresh;

  // ==========================================
  // measurement timing
  // sleep stops the period counter, so no new measurement starts; one already in its busy window still samples [R03]
  wire tick = !sleeping && per_cnt_ff == PW'(MEAS_PERIOD - 1); // [R01]
  wire sample_now = busy_cnt_ff == BW'(1);
  wire [15:0] conc_new = sat_sub(raw_sample, zero_ff);
  wire [3:0] sh = filt_shift(filt_set_ff);
  // larger setting, larger shift: more smoothing, slower response [R12]
  wire [15:0] up_step = 16'((conc_new - filt_ff) >> sh);
  wire [15:0] dn_step = 16'((filt_ff - conc_new) >> sh);
  wire [15:0] filt_new = (conc_new >= filt_ff) ? filt_ff + up_step : filt_ff - dn_step;

  // ==========================================
  // zero request pins
  wire n2_low = n2_sync_ff[1] == n2_sync_ff[2] ? !n2_sync_ff[2] : n2_lvl_ff;
  wire fa_low = fa_sync_ff[1] == fa_sync_ff[2] ? !fa_sync_ff[2] : fa_lvl_ff;
  // release before the hold time clears the count, nothing starts [R16]
  wire n2_fire = n2_low && !sleeping && n2_cnt_ff == ZW'(ZERO_HOLD - 1) && !n2_done_ff; // [R09]
  wire fa_fire = fa_low && !sleeping && fa_cnt_ff == ZW'(ZERO_HOLD - 1) && !fa_done_ff;
  wire do_n2 = n2_fire || (wr_cmd && pwdata[CMD_N2_BIT]);
  wire do_fa = fa_fire || (wr_cmd && pwdata[CMD_FRESH_BIT]);
  // nitrogen reference is zero; fresh air uses the writable reference [R14] [R15]
  wire [15:0] zero_ref = do_n2 ? N2_REF : fresh_ref_ff;
  wire boot_mode_ok = nv_mode_in == GZC_POLL;
  wire mode_keep = wr_ctrl && (wr_mode == GZC_STREAM || wr_mode == GZC_POLL) && wr_mode != nv_out_ff;

  // ==========================================
  // next values
  wire [PW-1:0] nxt_per_cnt = (tick || sleeping) ? '0 : per_cnt_ff + PW'(1);
  wire [BW-1:0] nxt_busy_cnt = tick ? BW'(BUSY_LEN) : (busy ? busy_cnt_ff - BW'(1) : '0);
  // first result seeds the filter so it does not ramp up from zero
  wire [15:0] nxt_filt = valid_ff ? filt_new : conc_new;
  wire stream_out = sample_now && mode_ff == GZC_STREAM;
  wire nxt_tx_valid = stream_out || poll_req; // [R07] [R02]
  // stream only in mode 1; poll answers with the held result
  wire [15:0] nxt_tx_data = stream_out ? nxt_filt : (poll_req ? filt_ff : tx_data_ff); // [R01] [R07]
  wire zero_load = (do_n2 || do_fa) && !sleeping;
  // sleep holds the counts at zero [R17]
  wire [ZW-1:0] nxt_n2_cnt = (n2_low && !sleeping && !n2_fire && !n2_done_ff) ? n2_cnt_ff + ZW'(1) : '0; // [R16]
  wire [ZW-1:0] nxt_fa_cnt = (fa_low && !sleeping && !fa_fire && !fa_done_ff) ? fa_cnt_ff + ZW'(1) : '0; // [R16]
  // one zero per low pulse, rearmed on release
  wire nxt_n2_done = n2_low && (n2_done_ff || n2_fire);
  wire nxt_fa_done = fa_low && (fa_done_ff || fa_fire);

  // ==========================================
  // registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_ff <= GZC_STREAM; // [R05]
      boot_ff <= 1'b1;
      nv_out_ff <= GZC_STREAM;
      nv_wr_ff <= 1'b0;
    end else begin
      boot_ff <= 1'b0;
      nv_wr_ff <= mode_keep; // [R08]
      if (boot_ff) begin
        mode_ff <= boot_mode_ok ? GZC_POLL : GZC_STREAM; // [R05] [R08]
        nv_out_ff <= boot_mode_ok ? GZC_POLL : GZC_STREAM;
      end else if (wr_ctrl) begin
        mode_ff <= gzc_mode_t'(wr_mode);
        if (mode_keep) begin
          nv_out_ff <= wr_mode;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filt_set_ff <= FILT_RST;
      fresh_ref_ff <= FRESH_RST;
    end else begin
      if (wr_ctrl) begin
        filt_set_ff <= pwdata[CTRL_FILT_LSB +: 8]; // [R12]
      end
      if (wr_fresh) begin
        fresh_ref_ff <= pwdata[15:0]; // [R15]
      end
    end
  end

  // the period counter parks at zero while asleep
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      per_cnt_ff <= '0;
      busy_cnt_ff <= '0;
      trig_ff <= 1'b0;
    end else begin
      per_cnt_ff <= nxt_per_cnt;
      busy_cnt_ff <= nxt_busy_cnt;
      trig_ff <= tick;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_raw_ff <= 16'h0000;
      conc_ff <= 16'h0000;
      filt_ff <= 16'h0000;
      valid_ff <= 1'b0;
    end else if (sample_now) begin
      last_raw_ff <= raw_sample;
      conc_ff <= conc_new;
      filt_ff <= nxt_filt;
      valid_ff <= 1'b1;
    end
  end

  // a new zero overwrites the old one, nothing accumulates
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zero_ff <= 16'h0000;
    end else if (zero_load) begin
      zero_ff <= sat_sub(last_raw_ff, zero_ref); // [R10]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_valid_ff <= 1'b0;
      tx_data_ff <= 16'h0000;
    end else begin
      tx_valid_ff <= nxt_tx_valid;
      tx_data_ff <= nxt_tx_data;
    end
  end

  // three stages; a level counts once the last two agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      n2_sync_ff <= 3'b111;
      fa_sync_ff <= 3'b111;
      n2_lvl_ff <= 1'b0;
      fa_lvl_ff <= 1'b0;
    end else begin
      n2_sync_ff <= {n2_sync_ff[1:0], n2_zero_n};
      fa_sync_ff <= {fa_sync_ff[1:0], fresh_zero_n};
      n2_lvl_ff <= n2_low;
      fa_lvl_ff <= fa_low;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      n2_cnt_ff <= '0;
      fa_cnt_ff <= '0;
      n2_done_ff <= 1'b0;
      fa_done_ff <= 1'b0;
    end else begin
      n2_cnt_ff <= nxt_n2_cnt;
      fa_cnt_ff <= nxt_fa_cnt;
      n2_done_ff <= nxt_n2_done;
      fa_done_ff <= nxt_fa_done;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
    end else begin
      pready_ff <= pending; // [R03]
      pslverr_ff <= pending && acc_err; // [R04]
      prdata_ff <= (pending && !pwrite && !acc_err) ? rd_mux : 32'h00000000;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign nv_mode_out = nv_out_ff;
  assign nv_mode_wr = nv_wr_ff;
  assign meas_trig = trig_ff;
  assign tx_valid = tx_valid_ff;
  assign tx_data = tx_data_ff;
endmodule : gzc_top

// File: core/gzc_pkg.sv
package gzc_pkg;
  // ==========================================
  // clock and timing
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned MEAS_PER_S = 2;
  localparam int unsigned ZERO_LOW_MS = 3000;
  localparam int unsigned CMD_DEFER_MS = 10;
  localparam int unsigned MEAS_CYC = CLK_HZ / MEAS_PER_S;
  // least time: whole cycles per ms times ms, no rounding up
  localparam int unsigned ZERO_LOW_CYC = (ZERO_LOW_MS * (CLK_HZ / 1000) + 0) ;
  // longest time: round down
  localparam int unsigned DEFER_CYC = (CMD_DEFER_MS * CLK_HZ) / 1000;
  // ==========================================
  // register offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_FILT = 8'h08;
  localparam logic [7:0] OFS_RAW = 8'h0C;
  localparam logic [7:0] OFS_ZERO = 8'h10;
  localparam logic [7:0] OFS_FRESH = 8'h14;
  localparam logic [7:0] OFS_CMD = 8'h18;
  // ==========================================
  // fields
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_FILT_LSB = 8;
  localparam int unsigned CMD_N2_BIT = 0;
  localparam int unsigned CMD_FRESH_BIT = 1;
  localparam int unsigned CMD_POLL_BIT = 2;
  // ==========================================
  // reset values
  localparam logic [7:0] FILT_RST = 8'h10;
  localparam logic [15:0] FRESH_RST = 16'h0190;
  localparam logic [15:0] N2_REF = 16'h0000;
  typedef enum logic [1:0] {
    GZC_SLEEP = 2'b00,
    GZC_STREAM = 2'b01,
    GZC_POLL = 2'b10
  } gzc_mode_t;
endpackage : gzc_pkg

// File: tb/gzc_monitor.sv
`timescale 1ns/1ps
// ==========
// port checks
module gzc_monitor (
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr,
  input logic [1:0] nv_mode_out,
  input logic nv_mode_wr,
  input logic meas_trig,
  input logic tx_valid
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_pulse_a: assert property (pready |=> !pready) else $error("long pready");
  ready_cause_a: assert property (pready |-> $past(psel && penable)) else $error("pready no access");
  err_ready_a: assert property (pslverr |-> pready) else $error("lone pslverr");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("prdata not idle");
  trig_gap_a: assert property (meas_trig |=> !meas_trig [*8]) else $error("trig too close");
  tx_pulse_a: assert property (tx_valid |=> !tx_valid) else $error("long tx_valid");
  nv_code_a: assert property (nv_mode_wr |-> nv_mode_out inside {2'h1, 2'h2}) else $error("bad nv code");
  nv_pulse_a: assert property (nv_mode_wr |=> !nv_mode_wr) else $error("long nv write");
  cover property (pslverr);
  cover property (tx_valid);
  cover property (nv_mode_wr);
endmodule : gzc_monitor
bind gzc_top gzc_monitor gzc_monitor_inst (.pclk, .presetn, .psel, .penable, .prdata, .pready, .pslverr,
  .nv_mode_out, .nv_mode_wr, .meas_trig, .tx_valid);

// File: tb/gzc_host_model.sv
`timescale 1ns/1ps
// ==========
// mode store and front end
module gzc_host_model (
  input logic pclk,
  input logic [15:0] conc,
  input logic [1:0] nv_mode_out,
  input logic nv_mode_wr,
  output logic [1:0] nv_mode_in,
  output logic [15:0] raw_sample
);
  // not cleared by presetn: it stands for flash
  initial nv_mode_in = 2'h1;
  always @(posedge pclk) begin
    if (nv_mode_wr) nv_mode_in <= nv_mode_out;
    raw_sample <= conc;
  end
endmodule : gzc_host_model

// File: tb/tb.sv
`timescale 1ns/1ps
module tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, n2_n = 1, fr_n = 1, nv_wr, trig, txv;
  logic pready, pslverr;
  logic [31:0] paddr = 0, pwdata = 0, prdata;
  logic [15:0] conc, raw, txd;
  logic [1:0] nv_in, nv_out;
  int failures = 0, n_checks = 0, seed = 45459, k;
  gzc_top #(.MEAS_PERIOD(200), .ZERO_HOLD(50), .BUSY_LEN(10)) gzc_top_inst (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .raw_sample(raw), .nv_mode_in(nv_in),
    .nv_mode_out(nv_out), .nv_mode_wr(nv_wr), .meas_trig(trig), .tx_valid(txv), .tx_data(txd),
    .n2_zero_n(n2_n), .fresh_zero_n(fr_n));
  gzc_host_model gzc_host_model_inst (.pclk, .conc, .nv_mode_out(nv_out), .nv_mode_wr(nv_wr),
    .nv_mode_in(nv_in), .raw_sample(raw));
  initial forever #50 pclk = ~pclk;
  // ==========
  // checks and bus
  task report_and_stop;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : report_and_stop
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  function logic [31:0] zero_of(input logic [15:0] r, input logic [15:0] ref_v);
    return {16'h0, r - ref_v};
  endfunction : zero_of
  task acc(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [31:0] exp, input logic ee);
    int i;
    @(posedge pclk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    i = 0;
    do begin @(posedge pclk); i++; end while (pready !== 1'b1 && i < 60);
    if (!w) chk(prdata, exp);
    chk({31'h0, pslverr}, {31'h0, ee});
    psel <= 0; penable <= 0;
    if (pready !== 1'b1) begin failures++; report_and_stop; end
  endtask : acc
  task wait_tx(input int lim, input logic [15:0] exp);
    int i;
    i = 0;
    do begin @(posedge pclk); i++; end while (txv !== 1'b1 && i < lim);
    chk({31'h0, txv}, 32'h1);
    chk({16'h0, txd}, {16'h0, exp});
    if (txv !== 1'b1) report_and_stop;
  endtask : wait_tx
  task pin(input logic fresh, input int n);
    if (fresh) fr_n <= 0; else n2_n <= 0;
    repeat (n) @(posedge pclk);
    fr_n <= 1; n2_n <= 1;
    repeat (10) @(posedge pclk);
  endtask : pin
  // ==========
  // scenarios
  initial begin
    conc = 16'h1000 | 16'($random(seed) & 32'h0FFF);
    repeat (4) @(posedge pclk);
    presetn <= 1;
    repeat (2) @(posedge pclk);
    acc(0, 32'h00, 0, 32'h1001, 0);
    wait_tx(300, conc);
    acc(0, 32'h0C, 0, {16'h0, conc}, 0);
    acc(0, 32'h40, 0, 0, 1); // unmapped offset
    acc(1, 32'h00, 32'h2002, 0, 0);
    acc(1, 32'h18, 32'h4, 0, 0);
    wait_tx(5, conc);
    k = 0;
    repeat (250) @(posedge pclk) if (txv === 1'b1) k++;
    chk(k, 0);
    pin(0, 30);
    acc(0, 32'h10, 0, 0, 0);
    pin(0, 70);
    acc(0, 32'h10, 0, zero_of(conc, 0), 0);
    acc(1, 32'h18, 32'h2, 0, 0);
    acc(0, 32'h10, 0, zero_of(conc, 16'd400), 0);
    acc(1, 32'h00, 32'h2000, 0, 0);
    acc(0, 32'h0C, 0, 0, 1);
    acc(1, 32'h18, 32'h1, 0, 1);
    pin(0, 70);
    pin(1, 70);
    acc(1, 32'h00, 32'h2000, 0, 0);
    acc(0, 32'h10, 0, zero_of(conc, 16'd400), 0);
    k = 0;
    repeat (250) @(posedge pclk) if (trig === 1'b1) k++;
    chk(k, 0);
    presetn <= 0;
    repeat (4) @(posedge pclk);
    presetn <= 1;
    repeat (2) @(posedge pclk);
    acc(0, 32'h00, 0, 32'h1002, 0);
    report_and_stop;
  end
endmodule : tb
